/* bench/qrs_ctrl_model.sv */
// Controller model driving the burst SRAM link pins
`timescale 1ns/1ps
`default_nettype none
module qrs_ctrl_model (
	input wire logic sys_clk,
	output logic pos_clock,
	output logic neg_clock,
	output logic write_port_select_n,
	output logic read_port_select_n,
	output logic [qrs_pkg::ADDR_W-1:0] addr,
	output logic [qrs_pkg::DATA_W-1:0] write_data,
	output logic [qrs_pkg::LANES-1:0] byte_write_select_n,
	output int ph,
	output int rise_no
);
	int overrun;
	initial begin
		overrun = 0;
		ph = 10;
		rise_no = 0;
		pos_clock = 1'b0;
		neg_clock = 1'b1;
		write_port_select_n = 1'b1;
		read_port_select_n = 1'b1;
		addr = '0;
		write_data = '0;
		byte_write_select_n = 2'h3;
	end
	always @(posedge sys_clk) begin
		ph <= (ph == 19) ? 0 : ph + 1;
		pos_clock <= (ph == 19 || ph < 9);
		neg_clock <= !(ph == 19 || ph < 9);
		rise_no <= rise_no + int'(ph == 19 || ph == 9);
	end
	task automatic wait_ph(input int p);
		int i;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (ph != p && i < 40);
		if (ph != p) begin
			overrun++;
		end
	endtask
	// Command on a rise, then four data beats
	task automatic access(input logic wr, input logic rd, input logic [qrs_pkg::ADDR_W-1:0] a,
		input logic [4*qrs_pkg::DATA_W-1:0] d, input logic [4*qrs_pkg::LANES-1:0] bw);
		wait_ph(14);
		write_port_select_n <= !wr;
		read_port_select_n <= !rd;
		addr <= a;
		wait_ph(4);
		write_port_select_n <= 1'b1;
		read_port_select_n <= 1'b1;
		addr <= ~a;
		for (int n = 0; n < 4; n++) begin
			wait_ph(n[0] ? 4 : 14);
			write_data <= d[n*qrs_pkg::DATA_W +: qrs_pkg::DATA_W];
			byte_write_select_n <= bw[n*qrs_pkg::LANES +: qrs_pkg::LANES];
		end
		wait_ph(14);
		write_data <= ~write_data;
	endtask
endmodule
`default_nettype wire

/* bench/test_qrs_port.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module test_qrs_port;
	logic sys_clk, reset_n, pll_disable_n, pos_clock, neg_clock, wsel_n, rsel_n, mon_on;
	logic [qrs_pkg::ADDR_W-1:0] addr, a;
	logic [qrs_pkg::DATA_W-1:0] write_data, read_data_out;
	logic [qrs_pkg::LANES-1:0] bsel_n;
	logic read_data_oe, read_valid_out, echo_clock_out, echo_clock_out_n;
	int ph, rise_no, fails, n_checks, seed;
	logic [qrs_pkg::DATA_W-1:0] mem [int];
	logic [31:0] exp_q [$];
	logic [31:0] obs_q [$];
	qrs_ctrl_model ctrl (.sys_clk(sys_clk), .pos_clock(pos_clock), .neg_clock(neg_clock),
		.write_port_select_n(wsel_n), .read_port_select_n(rsel_n), .addr(addr),
		.write_data(write_data), .byte_write_select_n(bsel_n), .ph(ph), .rise_no(rise_no));
	qrs_port uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .pos_clock(pos_clock),
		.neg_clock(neg_clock), .write_port_select_n(wsel_n), .read_port_select_n(rsel_n),
		.addr(addr), .write_data(write_data), .byte_write_select_n(bsel_n),
		.pll_disable_n(pll_disable_n), .read_data_out(read_data_out),
		.read_data_oe(read_data_oe), .read_valid_out(read_valid_out),
		.echo_clock_out(echo_clock_out), .echo_clock_out_n(echo_clock_out_n));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Output sampling well after each link rise
	always @(posedge sys_clk) begin
		if (mon_on && (ph == 9 || ph == 19)) begin
			check(32'(echo_clock_out), 32'(ph == 9));
			check(32'(echo_clock_out_n), 32'(ph != 9));
			if (read_valid_out === 1'b1) begin
				obs_q.push_back({rise_no[13:0], read_data_out});
				check(32'(read_data_oe), 32'h1);
			end else if (ph == 19) begin
				check(32'(read_data_oe), 32'h0);
			end
		end
	end
	// Reference memory updated lane by lane per beat
	task automatic op(input logic wr, input logic rd, input logic [7:0] bw);
		logic [71:0] d;
		int r;
		int k;
		for (int n = 0; n < 4; n++) begin
			d[n*18 +: 18] = 18'($random(seed));
		end
		ctrl.access(wr, rd, a, d, bw);
		r = rise_no - 5;
		for (int n = 0; n < 4; n++) begin
			k = int'({a, n[1:0]});
			for (int l = 0; l < 2; l++) begin
				if (wr && !bw[n*2+l]) begin
					mem[k][l*9 +: 9] = d[n*18+l*9 +: 9];
				end
			end
			if (rd) begin
				exp_q.push_back({14'(r + (pll_disable_n ? 5 : 2) + n), mem[k]});
			end
		end
	endtask
	initial begin
		#400000;
		fails++;
		summarize();
	end
	initial begin
		reset_n = 1'b0;
		pll_disable_n = 1'b1;
		mon_on = 1'b0;
		seed = 32'h2115;
		fails = 0;
		n_checks = 0;
		a = '0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (40) @(posedge sys_clk);
		mon_on <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			a = 19'($random(seed));
			op(1'b1, 1'b0, 8'h00);
			op(1'b1, 1'b0, 8'($random(seed)));
			op(1'b0, 1'b0, 8'h00);
			op(1'b0, 1'b1, 8'h00);
		end
		op(1'b1, 1'b1, 8'($random(seed)));
		repeat (40) @(posedge sys_clk);
		pll_disable_n <= 1'b0;
		repeat (40) @(posedge sys_clk);
		op(1'b0, 1'b1, 8'h00);
		repeat (100) @(posedge sys_clk);
		check(obs_q.size(), exp_q.size());
		foreach (exp_q[i]) begin
			check(obs_q[i], exp_q[i]);
		end
		check(ctrl.overrun, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire

/* design/qrs_mem.sv */
// Burst word array with per-lane write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module qrs_mem (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [qrs_pkg::WORD_ADDR_W-1:0] wr_addr,
	input wire logic [qrs_pkg::DATA_W-1:0] wr_data,
	input wire logic [qrs_pkg::LANES-1:0] wr_lane_n,
	input wire logic rd_en,
	input wire logic [qrs_pkg::WORD_ADDR_W-1:0] rd_addr,
	output var logic [qrs_pkg::DATA_W-1:0] rd_data
);
	// -------------------------------------------------
	// One array per byte lane
	// -------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < qrs_pkg::LANES; g = g + 1) begin : lane
			logic [qrs_pkg::LANE_W-1:0] mem [0:(1 << qrs_pkg::WORD_ADDR_W)-1];
			logic [qrs_pkg::LANE_W-1:0] rd_lane_r;
			// [R4] [R6] deselected lane untouched
			always_ff @(posedge clk) begin
				if (ce && wr_en && !wr_lane_n[g]) begin
					mem[wr_addr] <= wr_data[g*qrs_pkg::LANE_W +: qrs_pkg::LANE_W];
				end
				if (ce && rd_en) begin
					rd_lane_r <= mem[rd_addr];
				end
			end
			assign rd_data[g*qrs_pkg::LANE_W +: qrs_pkg::LANE_W] = rd_lane_r;
		end
	endgenerate
endmodule
`default_nettype wire

/* design/qrs_pkg.sv */
// Shared constants for the burst SRAM port
package qrs_pkg;
	// -------------------------------------------------
	// Widths (narrow variant)
	// -------------------------------------------------
	localparam int DATA_W = 18;
	localparam int ADDR_W = 19;
	localparam int LANES = 2;
	localparam int LANE_W = 9;
	localparam int BURST = 4;
	localparam int BEAT_W = 2;
	localparam int WORD_ADDR_W = ADDR_W + BEAT_W;
	localparam int SYNC_LEN = 3;
	// -------------------------------------------------
	// Read latency in clock half-cycles
	// -------------------------------------------------
	localparam int LAT_PLL = 5;
	localparam int LAT_NOPLL = 2;
	localparam int LINE_LEN = LAT_PLL;
	localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
endpackage

/* design/qrs_port.sv */
// Burst SRAM pin-side port: command capture, write bursts, DDR read bursts
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] Write data taken on both clock rises
// [R2] Write select low on rise starts write
// [R3] Write select high ignores write data
// [R4] Each byte select gates one 9-bit lane
// [R5] Byte selects sampled with their data word
// [R6] Unselected lanes keep stored content
// [R7] Shared address sampled on positive rise
// [R8] Nineteen address bits, burst of four
// [R9] Address ignored for deselected port
// [R10] Controller may permute address bits
// [R11] Read select low on rise starts read
// [R12] Each read returns four sequential words
// [R13] Idle read tristates after next complement rise
// [R14] Read data launched on both clock rises
// [R15] Valid flag marks driven read data
// [R16] Accesses start on positive clock rise
// [R17] Free-running echo clocks follow positive clock
// [R18] PLL off gives one-cycle read latency
// [R19] Write beats follow command over two cycles
// [R20] PLL on gives 2.5 cycle latency
// [R21] Read after pending write sees new data
module qrs_port (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic pos_clock,
	input wire logic neg_clock,
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire logic [qrs_pkg::ADDR_W-1:0] addr,
	input wire logic [qrs_pkg::DATA_W-1:0] write_data,
	input wire logic [qrs_pkg::LANES-1:0] byte_write_select_n,
	input wire logic pll_disable_n,
	output logic [qrs_pkg::DATA_W-1:0] read_data_out,
	output logic read_data_oe,
	output logic read_valid_out,
	output logic echo_clock_out,
	output logic echo_clock_out_n
);
	// -------------------------------------------------
	// State
	// -------------------------------------------------
	typedef struct packed {
		logic [qrs_pkg::SYNC_LEN-1:0] k_sy;
		logic [qrs_pkg::SYNC_LEN-1:0] kn_sy;
		logic [qrs_pkg::SYNC_LEN-1:0] wps_sy;
		logic [qrs_pkg::SYNC_LEN-1:0] rps_sy;
		logic [qrs_pkg::SYNC_LEN-1:0] pll_sy;
		logic [qrs_pkg::SYNC_LEN-1:0][qrs_pkg::ADDR_W-1:0] a_sy;
		logic [qrs_pkg::SYNC_LEN-1:0][qrs_pkg::DATA_W-1:0] d_sy;
		logic [qrs_pkg::SYNC_LEN-1:0][qrs_pkg::LANES-1:0] bw_sy;
		logic k_lvl;
		logic kn_lvl;
		logic [qrs_pkg::SYNC_LEN-1:0] fill;
		logic k_ok;
		logic kn_ok;
		logic wr_pend;
		logic [qrs_pkg::ADDR_W-1:0] wr_pend_a;
		logic wr_act;
		logic [qrs_pkg::ADDR_W-1:0] wr_a;
		logic [qrs_pkg::BEAT_W-1:0] wr_beat;
		logic [qrs_pkg::LINE_LEN-1:0] rl_v;
		logic [qrs_pkg::LINE_LEN-1:0][qrs_pkg::ADDR_W-1:0] rl_a;
		logic rd_act;
		logic [qrs_pkg::ADDR_W-1:0] rd_a;
		logic [qrs_pkg::BEAT_W-1:0] rd_beat;
		logic mr_go;
		logic [qrs_pkg::WORD_ADDR_W-1:0] mr_a;
		logic mr_idle;
		logic mr_kn;
		logic mq_go;
		logic mq_idle;
		logic mq_kn;
		logic ek_d;
		logic [qrs_pkg::DATA_W-1:0] q;
		logic q_oe;
		logic qv;
		logic echo;
		logic echo_n;
	} qrs_state_t;

	qrs_state_t s_r;
	qrs_state_t s_nxt;
	logic rise_k;
	logic rise_kn;
	logic edge_any;
	logic w_go;
	logic [qrs_pkg::ADDR_W-1:0] w_a;
	logic [qrs_pkg::BEAT_W-1:0] w_b;
	logic r_go;
	logic [qrs_pkg::ADDR_W-1:0] r_a;
	logic [qrs_pkg::BEAT_W-1:0] r_b;
	logic [qrs_pkg::DATA_W-1:0] mem_rdata;
	logic wps_n;
	logic rps_n;
	logic pll_on;
	logic [qrs_pkg::ADDR_W-1:0] a_in;

	assign wps_n = s_r.wps_sy[2];
	assign rps_n = s_r.rps_sy[2];
	assign pll_on = s_r.pll_sy[2];
	assign a_in = s_r.a_sy[2];

	// -------------------------------------------------
	// Burst array
	// -------------------------------------------------
	// [R5] [R8] lanes ride with word, burst address
	qrs_mem u_mem (
		.clk(sys_clk),
		.ce(clk_en),
		.wr_en(w_go),
		.wr_addr({w_a, w_b}),
		.wr_data(s_r.d_sy[2]),
		.wr_lane_n(s_r.bw_sy[2]),
		.rd_en(s_r.mr_go),
		.rd_addr(s_r.mr_a),
		.rd_data(mem_rdata)
	);

	// -------------------------------------------------
	// Next state
	// -------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.k_sy = {s_r.k_sy[1:0], pos_clock};
		s_nxt.kn_sy = {s_r.kn_sy[1:0], neg_clock};
		s_nxt.wps_sy = {s_r.wps_sy[1:0], write_port_select_n};
		s_nxt.rps_sy = {s_r.rps_sy[1:0], read_port_select_n};
		s_nxt.pll_sy = {s_r.pll_sy[1:0], pll_disable_n};
		s_nxt.a_sy = {s_r.a_sy[1:0], addr};
		s_nxt.d_sy = {s_r.d_sy[1:0], write_data};
		s_nxt.bw_sy = {s_r.bw_sy[1:0], byte_write_select_n};
		// [R16] edges of both input clocks
		s_nxt.fill = {s_r.fill[1:0], 1'b1};
		rise_k = s_r.k_ok && s_r.k_sy[1] && s_r.k_sy[2] && !s_r.k_lvl;
		rise_kn = s_r.kn_ok && s_r.kn_sy[1] && s_r.kn_sy[2] && !s_r.kn_lvl;
		edge_any = rise_k || rise_kn;
		// No edge until a real settled level is known
		if (s_r.fill[2] && s_r.k_sy[1] == s_r.k_sy[2]) begin
			s_nxt.k_lvl = s_r.k_sy[2];
			s_nxt.k_ok = 1'b1;
		end
		if (s_r.fill[2] && s_r.kn_sy[1] == s_r.kn_sy[2]) begin
			s_nxt.kn_lvl = s_r.kn_sy[2];
			s_nxt.kn_ok = 1'b1;
		end
		// [R1] write beat on either rise
		w_go = 1'b0;
		w_a = s_r.wr_a;
		w_b = s_r.wr_beat;
		if (edge_any && s_r.wr_act) begin
			w_go = 1'b1;
		end else if (rise_k && s_r.wr_pend) begin
			w_go = 1'b1;
			w_a = s_r.wr_pend_a;
			w_b = '0;
			s_nxt.wr_pend = 1'b0;
		end
		// [R19] four beats over two cycles
		if (w_go) begin
			s_nxt.wr_a = w_a;
			s_nxt.wr_beat = w_b + 2'h1;
			s_nxt.wr_act = (w_b != qrs_pkg::LAST_BEAT);
		end
		// [R2] [R3] [R7] write command capture
		if (rise_k && !wps_n) begin
			s_nxt.wr_pend = 1'b1;
			s_nxt.wr_pend_a = a_in;
		end
		// [R12] read burst sequencing
		r_go = 1'b0;
		r_a = s_r.rd_a;
		r_b = s_r.rd_beat;
		if (edge_any) begin
			s_nxt.rl_v = s_r.rl_v >> 1;
			s_nxt.rl_a = s_r.rl_a >> qrs_pkg::ADDR_W;
			if (s_r.rd_act) begin
				r_go = 1'b1;
			end else if (s_r.rl_v[0]) begin
				r_go = 1'b1;
				r_a = s_r.rl_a[0];
				r_b = '0;
			end
		end
		if (r_go) begin
			s_nxt.rd_a = r_a;
			s_nxt.rd_beat = r_b + 2'h1;
			s_nxt.rd_act = (r_b != qrs_pkg::LAST_BEAT);
		end
		// [R21] array read one cycle after the write
		s_nxt.mr_go = r_go;
		s_nxt.mr_a = {r_a, r_b};
		s_nxt.mr_idle = edge_any && !r_go;
		s_nxt.mr_kn = rise_kn;
		// [R11] [R9] [R18] [R20] read command into latency line
		if (rise_k && !rps_n) begin
			if (pll_on) begin
				s_nxt.rl_v[qrs_pkg::LAT_PLL-1] = 1'b1;
				s_nxt.rl_a[qrs_pkg::LAT_PLL-1] = a_in;
			end else begin
				s_nxt.rl_v[qrs_pkg::LAT_NOPLL-1] = 1'b1;
				s_nxt.rl_a[qrs_pkg::LAT_NOPLL-1] = a_in;
			end
		end
		s_nxt.mq_go = s_r.mr_go;
		s_nxt.mq_idle = s_r.mr_idle;
		s_nxt.mq_kn = s_r.mr_kn;
		// [R14] [R15] drive word and valid flag
		if (s_r.mq_go) begin
			s_nxt.q = mem_rdata;
			s_nxt.q_oe = 1'b1;
			s_nxt.qv = 1'b1;
		end else if (s_r.mq_idle) begin
			s_nxt.qv = 1'b0;
			// [R13] release on complement rise
			if (s_r.mq_kn) begin
				s_nxt.q_oe = 1'b0;
			end
		end
		// [R17] echo clocks aligned to data
		s_nxt.ek_d = s_r.k_lvl;
		s_nxt.echo = s_r.ek_d;
		s_nxt.echo_n = !s_r.ek_d;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign read_data_out = s_r.q;
	assign read_data_oe = s_r.q_oe;
	assign read_valid_out = s_r.qv;
	assign echo_clock_out = s_r.echo;
	assign echo_clock_out_n = s_r.echo_n;

	// -------------------------------------------------
	// Checks
	// -------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n || !clk_en);

	sequence rd_issue_s;
		s_r.mr_go ##1 s_r.mq_go;
	endsequence

	sequence wr_due_s;
		rise_k && s_r.wr_pend && !s_r.wr_act;
	endsequence

	wr_start_a: assert property (rise_k && !wps_n |=> s_r.wr_pend) // [R2]
		else $error("write command not captured");
	wr_ignore_a: assert property (rise_k && wps_n && !s_r.wr_act |=> !s_r.wr_pend) // [R3]
		else $error("deselected write still pending");
	wr_burst_a: assert property (w_go && w_b == qrs_pkg::LAST_BEAT |=> !s_r.wr_act) // [R19]
		else $error("write burst longer than four beats");
	rd_burst_a: assert property (r_go && r_b == 2'h0 |=> s_r.rd_act && s_r.rd_beat == 2'h1) // [R12]
		else $error("read burst did not continue");
	rd_lat_pll_a: assert property (rise_k && !rps_n && pll_on |=> s_r.rl_v[4]) // [R20]
		else $error("read latency slot wrong with PLL");
	rd_lat_nopll_a: assert property (rise_k && !rps_n && !pll_on |=> s_r.rl_v[1]) // [R18]
		else $error("read latency slot wrong without PLL");
	rd_drive_a: assert property (rd_issue_s |=> s_r.q_oe && s_r.qv) // [R14]
		else $error("read word not driven");
	rd_release_a: assert property (s_r.mq_idle && s_r.mq_kn && !s_r.mq_go |=> !s_r.q_oe && !s_r.qv) // [R13]
		else $error("read bus not released");
	echo_pair_a: assert property (s_r.ek_d |=> s_r.echo && !s_r.echo_n) // [R17]
		else $error("echo clock does not follow input clock");
	wr_first_a: assert property (wr_due_s |-> w_go && w_b == 2'h0) // [R19]
		else $error("write burst did not start on positive rise");
endmodule
`default_nettype wire
